// ===== core/sor_defines.vh
/*
 * shared constants of the signal routing option bank: register
 * offsets, field positions, reset values and trigger source codes.
 * assumes an 8-bit register port with byte-wide data.
 */
`ifndef SOR_DEFINES_VH
`define SOR_DEFINES_VH

// register offsets
`define SOR_OFS_ROUTE 8'h05
`define SOR_OFS_CLKDLY 8'h06
`define SOR_OFS_DLYMOD 8'h07

// signal_routing_options fields
`define SOR_TXMOD_BIT 7
`define SOR_SYNC_BIT 6
`define SOR_RXFLT_BIT 5
`define SOR_RXCAP_BIT 4
`define SOR_CMPCAP_BIT 3
`define SOR_RTCCAP_BIT 2
`define SOR_ADCSRC_HI 1
`define SOR_ADCSRC_LO 0

// clock_output_and_delay_status fields
`define SOR_TRIGGER_DELAY_ACTIVE_BIT 7
`define SOR_REF_CLOCK_OUT_ENABLE_BIT 3
`define SOR_BUSDIV_HI 2
`define SOR_BUSDIV_LO 0

// reset values
`define SOR_ROUTE_RST 8'h00
`define SOR_CLKDLY_RST 4'h0
`define SOR_DLYMOD_RST 8'h00

// converter trigger source codes
`define SOR_ADC_RTC 2'h0
`define SOR_ADC_MTIM 2'h1
`define SOR_ADC_INIT 2'h2
`define SOR_ADC_MATCH 2'h3

// answer for an unmapped read
`define SOR_RD_NONE 8'h00

`endif

// ===== core/sor_rise_det.v
/*
 * rising edge detector: one-cycle pulse for each low-to-high step.
 * assumes the input is already on clk.
 */
`timescale 1ns/1ps
`default_nettype none

module sor_rise_det (
    input wire clk, // system clock
    input wire rstn, // async reset, active low
    input wire level_in, // level to watch
    output wire rise_pulse // high in the same cycle a rise is seen, not registered
);

reg prev_reg;

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        prev_reg <= 1'b0;
    end else begin
        prev_reg <= level_in;
    end
end

// a source already high at reset release does not count as an edge
reg armed_reg;

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        armed_reg <= 1'b0;
    end else begin
        armed_reg <= 1'b1;
    end
end

assign rise_pulse = armed_reg & level_in & ~prev_reg;

endmodule // sor_rise_det

`default_nettype wire

// ===== core/sor_top.v
/*
 * signal routing option bank: two option registers plus a delay
 * modulo register that steer timer, serial, comparator and converter
 * trigger signals, and drive a clock out on one pin.
 * assumes peripherals on clk, serial_rx_line from a pin.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sor_defines.vh"

module sor_top #(
    parameter ADDR_W = 8, // register address width
    parameter DIV_W = 7 // prescaler width, 2**7 = 128
) (
    input wire clk, // 125 MHz bus clock
    input wire rstn, // async reset, active low
    input wire [ADDR_W-1:0] reg_addr, // register offset
    input wire [7:0] reg_wdata, // write data
    input wire reg_wr, // write strobe
    input wire reg_rd, // read strobe
    output reg [7:0] reg_rdata, // read data, cycle after strobe
    input wire serial_tx_line, // transmit from serial port zero
    input wire flex_timer_zero_ch0_out, // timer zero channel 0 output
    output reg serial_tx_pin, // transmit toward the pin
    input wire serial_rx_line, // receive pin, asynchronous
    input wire cmp_filtered_rx, // receive line after comparator
    output reg serial_port_zero_rx_in, // receive into serial port zero
    output reg flex_timer_zero_ch1_in, // timer zero channel 1 input
    input wire cmp_out, // analog comparator output
    input wire rtc_overflow, // real time counter overflow
    output reg flex_timer_one_ch0_in, // timer one channel 0 input
    output reg flex_timer_one_ch1_in, // timer one channel 1 input
    output reg flex_timer_two_sync_trig, // pwm sync trigger, one cycle
    input wire modulo_timer_zero_overflow, // modulo timer zero overflow
    input wire flex_timer_two_init_trig, // timer two init trigger
    input wire flex_timer_two_match_trig, // timer two match trigger
    output reg adc_hw_trig, // converter trigger, one cycle
    input wire internal_ref_clock_out, // reference clock level
    output reg port_h_pin_two // clock output pin
);

// register state
reg tx_modulation_select_reg;
reg rx_comparator_filter_sel_reg;
reg rx_capture_route_sel_reg;
reg comparator_to_capture_sel_reg;
reg rtc_overflow_capture_sel_reg;
reg [1:0] adc_trigger_source_sel_reg;
reg ref_clock_out_enable_reg;
reg [2:0] bus_clock_out_divider_reg;
reg [7:0] delay_modulo_reg;

// decode
wire hit_route;
wire hit_clkdly;
wire hit_dlymod;

assign hit_route = (reg_addr == `SOR_OFS_ROUTE);
assign hit_clkdly = (reg_addr == `SOR_OFS_CLKDLY);
assign hit_dlymod = (reg_addr == `SOR_OFS_DLYMOD);

wire wr_route;
wire wr_clkdly;
wire wr_dlymod;

assign wr_route = reg_wr & hit_route;
assign wr_clkdly = reg_wr & hit_clkdly;
assign wr_dlymod = reg_wr & hit_dlymod;

// first option register, open to access at any time
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        tx_modulation_select_reg <= 1'b0;
        rx_comparator_filter_sel_reg <= 1'b0;
        rx_capture_route_sel_reg <= 1'b0;
        comparator_to_capture_sel_reg <= 1'b0;
        rtc_overflow_capture_sel_reg <= 1'b0;
        adc_trigger_source_sel_reg <= 2'h0;
    end else if (wr_route) begin
        tx_modulation_select_reg <= reg_wdata[`SOR_TXMOD_BIT];
        rx_comparator_filter_sel_reg <= reg_wdata[`SOR_RXFLT_BIT];
        rx_capture_route_sel_reg <= reg_wdata[`SOR_RXCAP_BIT];
        comparator_to_capture_sel_reg <= reg_wdata[`SOR_CMPCAP_BIT];
        rtc_overflow_capture_sel_reg <= reg_wdata[`SOR_RTCCAP_BIT];
        adc_trigger_source_sel_reg <= reg_wdata[`SOR_ADCSRC_HI:`SOR_ADCSRC_LO];
    end
end

// second option register, no sequencing restriction
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        ref_clock_out_enable_reg <= 1'b0;
        bus_clock_out_divider_reg <= 3'h0;
    end else if (wr_clkdly) begin
        ref_clock_out_enable_reg <= reg_wdata[`SOR_REF_CLOCK_OUT_ENABLE_BIT];
        bus_clock_out_divider_reg <= reg_wdata[`SOR_BUSDIV_HI:`SOR_BUSDIV_LO];
    end
end

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        delay_modulo_reg <= `SOR_DLYMOD_RST;
    end else if (wr_dlymod) begin
        delay_modulo_reg <= reg_wdata;
    end
end

// sync strobe: a write of 1 pulses once, the bit keeps no state
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        flex_timer_two_sync_trig <= 1'b0;
    end else begin
        flex_timer_two_sync_trig <= wr_route & reg_wdata[`SOR_SYNC_BIT];
    end
end

// receive pin synchroniser; first stage feeds only the second
reg rx_s1_reg;
reg rx_s2_reg;
reg rx_s3_reg;
reg rx_clean_reg;

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        rx_s1_reg <= 1'b1;
        rx_s2_reg <= 1'b1;
        rx_s3_reg <= 1'b1;
        rx_clean_reg <= 1'b1;
    end else begin
        rx_s1_reg <= serial_rx_line;
        rx_s2_reg <= rx_s1_reg;
        rx_s3_reg <= rx_s2_reg;
        if (rx_s2_reg == rx_s3_reg) begin
            rx_clean_reg <= rx_s3_reg;
        end
    end
end

// routing, every output registered
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        serial_tx_pin <= 1'b1;
        serial_port_zero_rx_in <= 1'b1;
        flex_timer_zero_ch1_in <= 1'b0;
        flex_timer_one_ch0_in <= 1'b0;
        flex_timer_one_ch1_in <= 1'b0;
    end else begin
        if (tx_modulation_select_reg) begin
            serial_tx_pin <= serial_tx_line & flex_timer_zero_ch0_out;
        end else begin
            serial_tx_pin <= serial_tx_line;
        end
        if (rx_comparator_filter_sel_reg) begin
            serial_port_zero_rx_in <= cmp_filtered_rx;
        end else begin
            serial_port_zero_rx_in <= rx_clean_reg;
        end
        flex_timer_zero_ch1_in <= rx_capture_route_sel_reg & rx_clean_reg;
        flex_timer_one_ch0_in <= comparator_to_capture_sel_reg & cmp_out;
        flex_timer_one_ch1_in <= rtc_overflow_capture_sel_reg & rtc_overflow;
    end
end

// bus clock prescaler, free running
reg [DIV_W-1:0] presc_cnt_reg;
wire [DIV_W-1:0] presc_cnt_next;
wire [DIV_W-1:0] presc_mask;
wire presc_tick;

assign presc_cnt_next = presc_cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
// code n gives mask of n ones, so tick every 2**n cycles
assign presc_mask = ~({DIV_W{1'b1}} << bus_clock_out_divider_reg);
assign presc_tick = ((presc_cnt_reg & presc_mask) == presc_mask);

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        presc_cnt_reg <= {DIV_W{1'b0}};
    end else begin
        presc_cnt_reg <= presc_cnt_next;
    end
end

// divided clock level; code 000 toggles every cycle since a
// registered pin cannot carry the raw clock itself
reg bus_clk_div_reg;

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        bus_clk_div_reg <= 1'b0;
    end else if (bus_clock_out_divider_reg == 3'h0) begin
        bus_clk_div_reg <= ~bus_clk_div_reg;
    end else begin
        bus_clk_div_reg <= presc_cnt_next[bus_clock_out_divider_reg - 3'h1];
    end
end

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        port_h_pin_two <= 1'b0;
    end else if (ref_clock_out_enable_reg) begin
        port_h_pin_two <= internal_ref_clock_out;
    end else begin
        port_h_pin_two <= bus_clk_div_reg;
    end
end

// rising edges of every converter trigger source
wire rtc_rise;
wire mtim_rise;
wire init_rise;
wire match_rise;

sor_rise_det u_rtc_rise (
    .clk(clk),
    .rstn(rstn),
    .level_in(rtc_overflow),
    .rise_pulse(rtc_rise)
);

sor_rise_det u_mtim_rise (
    .clk(clk),
    .rstn(rstn),
    .level_in(modulo_timer_zero_overflow),
    .rise_pulse(mtim_rise)
);

sor_rise_det u_init_rise (
    .clk(clk),
    .rstn(rstn),
    .level_in(flex_timer_two_init_trig),
    .rise_pulse(init_rise)
);

sor_rise_det u_match_rise (
    .clk(clk),
    .rstn(rstn),
    .level_in(flex_timer_two_match_trig),
    .rise_pulse(match_rise)
);

// delayed-trigger start from the selected timer two edge
reg dly_start;

always @* begin
    case (adc_trigger_source_sel_reg)
        `SOR_ADC_INIT: dly_start = init_rise;
        `SOR_ADC_MATCH: dly_start = match_rise;
        default: dly_start = 1'b0;
    endcase
end

// one-shot delay counter; a fresh edge while counting restarts it
reg dly_active_reg;
reg [7:0] dly_cnt_reg;
reg dly_done;

always @* begin
    dly_done = dly_active_reg & presc_tick & (dly_cnt_reg == delay_modulo_reg);
end

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        dly_active_reg <= 1'b0;
        dly_cnt_reg <= 8'h00;
    end else if (dly_start) begin
        dly_active_reg <= 1'b1;
        dly_cnt_reg <= 8'h00;
    end else if (dly_done) begin
        dly_active_reg <= 1'b0;
    end else if (dly_active_reg && presc_tick) begin
        dly_cnt_reg <= dly_cnt_reg + 8'h01;
    end
end

// converter trigger selection
reg adc_trig_next;

always @* begin
    case (adc_trigger_source_sel_reg)
        `SOR_ADC_RTC: adc_trig_next = rtc_rise;
        `SOR_ADC_MTIM: adc_trig_next = mtim_rise;
        default: adc_trig_next = dly_done;
    endcase
end

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        adc_hw_trig <= 1'b0;
    end else begin
        adc_hw_trig <= adc_trig_next;
    end
end

// read path; sync strobe bit always reads back 0
reg [7:0] rd_next;

always @* begin
    if (hit_route) begin
        rd_next = {tx_modulation_select_reg, 1'b0,
            rx_comparator_filter_sel_reg, rx_capture_route_sel_reg,
            comparator_to_capture_sel_reg, rtc_overflow_capture_sel_reg,
            adc_trigger_source_sel_reg};
    end else if (hit_clkdly) begin
        rd_next = {dly_active_reg, 3'h0,
            ref_clock_out_enable_reg, bus_clock_out_divider_reg};
    end else if (hit_dlymod) begin
        rd_next = delay_modulo_reg;
    end else begin
        rd_next = `SOR_RD_NONE;
    end
end

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        reg_rdata <= 8'h00;
    end else if (reg_rd) begin
        reg_rdata <= rd_next;
    end else begin
        reg_rdata <= 8'h00;
    end
end

endmodule // sor_top

`default_nettype wire

// ===== tb/sor_top_monitor.sv
/* checker of the signal routing option bank, bound to sor_top.
   assumes one clock, async active-low reset, offsets from the defines. */
`timescale 1ns/1ps
`default_nettype none
`include "sor_defines.vh"
module sor_top_monitor #(
    parameter ADDR_W = 8
) (
    input wire logic clk, // bus clock
    input wire logic rstn, // reset, active low
    input wire logic [ADDR_W-1:0] reg_addr, // offset
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic serial_tx_line, // tx from port
    input wire logic flex_timer_zero_ch0_out, // modulator
    input wire logic serial_tx_pin, // tx to pin
    input wire logic serial_rx_line, // rx pin
    input wire logic cmp_filtered_rx, // filtered rx
    input wire logic serial_port_zero_rx_in, // rx to port
    input wire logic flex_timer_zero_ch1_in, // rx capture
    input wire logic flex_timer_one_ch1_in, // rtc capture
    input wire logic cmp_out, // comparator
    input wire logic flex_timer_one_ch0_in, // capture input
    input wire logic rtc_overflow, // counter overflow
    input wire logic modulo_timer_zero_overflow, // timer overflow
    input wire logic flex_timer_two_init_trig, // init trigger
    input wire logic flex_timer_two_sync_trig, // sync pulse
    input wire logic adc_hw_trig, // converter trigger
    input wire logic internal_ref_clock_out, // ref clock
    input wire logic port_h_pin_two // clock pin
);
    reg [7:0] route_reg;
    reg [7:0] dmod_reg;
    reg [3:0] cfg_reg;
    reg [7:0] run_reg;
    reg [8:0] age_reg;
    reg pin_reg;
    wire wr6 = reg_wr && reg_addr == `SOR_OFS_CLKDLY;
    wire sel_lvl = route_reg[0] ? modulo_timer_zero_overflow : rtc_overflow;
    wire [7:0] half = (cfg_reg[2:0] == 3'h0) ? 8'h01 : (8'h01 << (cfg_reg[2:0] - 3'h1));
    // shadow copies of the fields, so no design internals are needed
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            route_reg <= 8'h00;
            dmod_reg <= 8'h00;
            cfg_reg <= 4'h0;
            run_reg <= 8'h00;
            age_reg <= 9'h000;
            pin_reg <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `SOR_OFS_ROUTE) route_reg <= reg_wdata;
            if (reg_wr && reg_addr == `SOR_OFS_DLYMOD) dmod_reg <= reg_wdata;
            if (wr6) cfg_reg <= reg_wdata[3:0];
            age_reg <= wr6 ? 9'h000 : age_reg + {8'h00, age_reg != 9'h1ff};
            pin_reg <= port_h_pin_two;
            run_reg <= (pin_reg != port_h_pin_two) ? 8'h01 : run_reg + 8'h01;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_tx_route: assert property (
        $past(rstn) |-> serial_tx_pin == $past(serial_tx_line & (~route_reg[7] | flex_timer_zero_ch0_out)))
        else $error("tx pin routing wrong");
    chk_cmp_capture: assert property (
        $past(rstn) |-> flex_timer_one_ch0_in == $past(cmp_out & route_reg[3]))
        else $error("comparator capture wrong");
    // the synced receive path lags the pin by five edges
    chk_rx_select: assert property (
        $past(rstn, 6) |-> serial_port_zero_rx_in == ($past(route_reg[5]) ? $past(cmp_filtered_rx)
        : $past(serial_rx_line, 5))) else $error("receive routing wrong");
    chk_rx_capture: assert property (
        $past(rstn, 6) |-> flex_timer_zero_ch1_in == ($past(route_reg[4]) & $past(serial_rx_line, 5)))
        else $error("receive capture wrong");
    chk_rtc_capture: assert property (
        $past(rstn) |-> flex_timer_one_ch1_in == $past(rtc_overflow & route_reg[2]))
        else $error("rtc capture wrong");
    chk_sync_pulse: assert property (
        $past(rstn) |-> flex_timer_two_sync_trig == $past(reg_wr && reg_addr == `SOR_OFS_ROUTE
        && reg_wdata[6])) else $error("sync pulse wrong");
    chk_adc_edge: assert property (
        $past(rstn, 2) && route_reg[1:0] < 2'h2 && $rose(sel_lvl) |-> ##1 adc_hw_trig)
        else $error("converter trigger missing");
    chk_adc_rise_only: assert property (
        adc_hw_trig && $past(route_reg[1:0]) < 2'h2
        && $past(route_reg[1:0], 2) == $past(route_reg[1:0])
        |-> $past(sel_lvl) && !$past(sel_lvl, 2)) else $error("trigger without rise");
    chk_delay_zero: assert property (
        route_reg[1:0] == 2'h2 && dmod_reg == 8'h00 && cfg_reg[2:0] == 3'h0
        && $rose(flex_timer_two_init_trig) |-> ##2 adc_hw_trig) else $error("delayed trigger late");
    chk_ref_out: assert property (
        $past(rstn) && $past(cfg_reg[3]) |-> port_h_pin_two == $past(internal_ref_clock_out))
        else $error("ref clock pin wrong");
    chk_div_half: assert property (
        !cfg_reg[3] && age_reg > 9'd300 && pin_reg != port_h_pin_two |-> run_reg == half)
        else $error("divided clock period wrong");
endmodule // sor_top_monitor
bind sor_top sor_top_monitor #(.ADDR_W(ADDR_W)) mon (.clk, .rstn, .reg_addr, .reg_wdata,
    .reg_wr, .serial_tx_line, .flex_timer_zero_ch0_out, .serial_tx_pin, .serial_rx_line,
    .cmp_filtered_rx, .serial_port_zero_rx_in, .flex_timer_zero_ch1_in, .flex_timer_one_ch1_in, .cmp_out, .flex_timer_one_ch0_in,
    .rtc_overflow, .modulo_timer_zero_overflow, .flex_timer_two_init_trig, .flex_timer_two_sync_trig, .adc_hw_trig,
    .internal_ref_clock_out, .port_h_pin_two);
`default_nettype wire

// ===== tb/sor_periph_model.sv
/* peripheral model for the option bank: serial and comparator levels,
   a reference clock, and source pulses on request.
   assumes one-cycle fire strobes from the bench on clk. */
`timescale 1ns/1ps
`default_nettype none
module sor_periph_model (
    input wire logic clk, // bus clock
    input wire logic rstn, // reset, active low
    input wire logic [3:0] fire, // start rtc, mtim, init, match
    output var logic [3:0] src, // source levels, two cycles each
    output wire logic [4:0] lines, // tx, flex_timer_zero, cmp, filtered, rx
    output wire logic ref_clk // reference clock, period 6
);
    logic [3:0] fire_reg;
    logic [7:0] cnt_reg;
    // two-cycle pulses: a trigger taken on level would fire twice
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fire_reg <= 4'h0;
            src <= 4'h0;
            cnt_reg <= 8'h00;
        end else begin
            fire_reg <= fire;
            src <= fire | fire_reg;
            cnt_reg <= (cnt_reg == 8'hef) ? 8'h00 : cnt_reg + 8'h01;
        end
    end
    assign lines = {cnt_reg[4], cnt_reg[3] ^ cnt_reg[0], cnt_reg[2:0]};
    assign ref_clk = (cnt_reg % 8'h06) < 8'h03;
endmodule // sor_periph_model
`default_nettype wire

// ===== tb/sor_top_tb_top.sv
/* self-checking bench of the option bank: register tasks, routing,
   converter trigger, delay and clock-out scenarios.
   assumes design, model and checker compiled before it. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module sor_top_tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] fire = 4'h0;
    wire logic [3:0] src;
    wire logic [4:0] lines;
    wire logic ref_clk;
    wire logic [7:0] reg_rdata;
    wire logic adc;
    wire logic sync;
    int errors = 0;
    int compares = 0;
    int pulses = 0;
    int syncs = 0;
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (adc === 1'b1) pulses++;
        if (sync === 1'b1) syncs++;
    end
    sor_periph_model peer (.clk(clk), .rstn(rstn), .fire(fire), .src(src), .lines(lines),
        .ref_clk(ref_clk));
    sor_top uut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_tx_line(lines[0]),
        .flex_timer_zero_ch0_out(lines[1]), .serial_tx_pin(), .serial_rx_line(lines[4]),
        .cmp_filtered_rx(lines[3]), .serial_port_zero_rx_in(), .flex_timer_zero_ch1_in(), .cmp_out(lines[2]),
        .rtc_overflow(src[0]), .flex_timer_one_ch0_in(), .flex_timer_one_ch1_in(), .flex_timer_two_sync_trig(sync),
        .modulo_timer_zero_overflow(src[1]), .flex_timer_two_init_trig(src[2]), .flex_timer_two_match_trig(src[3]),
        .adc_hw_trig(adc), .internal_ref_clock_out(ref_clk), .port_h_pin_two());
    task automatic print_verdict;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ex, input string nm);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(nm, ex, reg_rdata)
    endtask
    task automatic fire_src(input int j);
        @(posedge clk);
        fire[j] <= 1'b1;
        @(posedge clk);
        fire[j] <= 1'b0;
    endtask
    // bounded wait; edges counted from the strobe edge of fire_src
    task automatic wait_adc(output int n);
        n = 1;
        while (adc !== 1'b1 && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 1000) begin
            errors++;
            print_verdict();
        end
    endtask
    initial begin
        int n;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        wr(8'h05, 8'h00);
        rd(8'h06, 8'h00, "opt3 reset");
        wr(8'h08, 8'hff);
        rd(8'h05, 8'h00, "unmapped write");
        rd(8'h08, 8'h00, "unmapped read");
        wr(8'h05, 8'hff);
        rd(8'h05, 8'hbf, "opt2 back");
        wr(8'h05, 8'h40);
        wr(8'h05, 8'h40);
        wr(8'h05, 8'h00);
        `CHK("sync pulses", 3, syncs)
        for (int r = 0; r < 2; r++) begin
            for (int s = 0; s < 4; s++) begin
                wr(8'h05, (r == 1 ? 8'hbc : 8'h00) | 8'(s));
                for (int j = 0; j < 4; j++) begin
                    n = pulses;
                    fire_src(j);
                    repeat (30) @(posedge clk);
                    `CHK("adc pulses", (j == s) ? 1 : 0, pulses - n)
                end
            end
        end
        wr(8'h07, 8'h14);
        wr(8'h05, 8'h02);
        fire_src(2);
        wait_adc(n);
        `CHK("delay cycles", 23, n)
        wr(8'h05, 8'h03);
        fire_src(3);
        repeat (4) @(posedge clk);
        rd(8'h06, 8'h80, "delay active");
        wait_adc(n);
        rd(8'h06, 8'h00, "delay idle");
        wr(8'h06, 8'h02);
        fire_src(3);
        wait_adc(n);
        `CHK("slow delay", 1'b1, n >= 83 && n <= 86)
        wr(8'h06, 8'hf8);
        rd(8'h06, 8'h08, "reserved bits");
        repeat (50) @(posedge clk);
        for (int d = 0; d < 8; d++) begin
            wr(8'h06, 8'(d));
            repeat (450) @(posedge clk);
        end
        rd(8'h06, 8'h07, "divider back");
        print_verdict();
    end
endmodule // sor_top_tb_top
`default_nettype wire
